/* shunt_trip_cal.sv */
// calibration trims and overcurrent trip for the first shunt converter
// assumes a 16-bit register port, synchronous inputs and a 200 MHz clock
`timescale 1ns/100ps

// Overview of operation
// - upper offset trim bits held read/write
// - low offset bits high byte, low byte zero
// - offset LSB equals conversion result LSB
// - gain multiplier is one plus code/65536
// - trip enable together with converter enable runs filter and comparator
// - fast path ignores go and halt bits
// - sinc3 fast filter, fixed ratio 64
// - flag after programmed consecutive outside samples
// - inside sample restarts count, no hysteresis
// - fault is any upper or lower flag
// - polarity bit picks fault drive level
// - pin 3 carries fault only when selected
// - above high threshold counts, 7FFF disables
// - below low threshold counts, 8000 disables
module shunt_trip_cal
  import trip_cal_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  // modulator and converter
  input  wire logic               mod_valid,
  input  wire logic               mod_bit,
  input  wire logic               converter_enable,
  input  wire logic               conv_valid,
  input  wire logic signed [23:0] conv_data,
  output logic                    cal_valid,
  output logic signed [23:0]      cal_data,
  // thresholds
  input  wire logic signed [15:0] upper_trip_threshold,
  input  wire logic signed [15:0] lower_trip_threshold,
  // pin 3
  input  wire logic               pin3_source_select,
  input  wire logic               pin3_output_format,
  input  wire logic               gpio3_level,
  output logic                    pin3_out,
  output logic                    pin3_oe,
  // status
  output logic                    upper_trip_flag,
  output logic                    lower_trip_flag,
  output logic                    trip_fault_output,
  output logic                    irq
);

  logic [23:0]        offset_trim_word;
  logic [15:0]        gain_trim_word;
  logic               trip_enable;
  logic               trip_polarity;
  logic               cfg_spare;
  logic [4:0]         trip_deglitch_count;
  logic [2:0]         irq_status;
  logic [2:0]         irq_mask;
  logic [2:0]         irq_event;
  logic               run;
  logic [7:0]         target;
  logic [1:0]         beyond;
  logic [1:0]         trip_rise;
  logic [1:0]         flag;
  logic [7:0]         trip_count [2];
  logic               wr_hit_status;
  logic               fault_level;
  logic               pin_value;

  fast_filter_if ff ();

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_trim_word    <= OFFSET_RESET;
      gain_trim_word      <= GAIN_RESET;
      trip_enable         <= CFG_RESET[CFG_EN_BIT];
      trip_polarity       <= CFG_RESET[CFG_POL_BIT];
      cfg_spare           <= CFG_RESET[CFG_SPARE_BIT];
      trip_deglitch_count <= CFG_RESET[CFG_NUM_MSB:CFG_NUM_LSB];
      irq_mask            <= IRQ_MASK_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_OFFSET_HIGH: offset_trim_word[23:8] <= reg_wdata;
        ADDR_OFFSET_LOW:  offset_trim_word[7:0]  <= reg_wdata[15:8];
        ADDR_GAIN:        gain_trim_word         <= reg_wdata;
        ADDR_TRIP_CFG: begin
          trip_enable         <= reg_wdata[CFG_EN_BIT];
          trip_polarity       <= reg_wdata[CFG_POL_BIT];
          cfg_spare           <= reg_wdata[CFG_SPARE_BIT];
          trip_deglitch_count <= reg_wdata[CFG_NUM_MSB:CFG_NUM_LSB];
        end
        ADDR_IRQ_MASK:    irq_mask <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      unique case (reg_addr)
        ADDR_OFFSET_HIGH: reg_rdata <= offset_trim_word[23:8];
        ADDR_OFFSET_LOW:  reg_rdata <= {offset_trim_word[7:0], 8'h00};
        ADDR_GAIN:        reg_rdata <= gain_trim_word;
        ADDR_TRIP_CFG:    reg_rdata <= {trip_enable, trip_polarity, cfg_spare,
                                        trip_deglitch_count, 8'h00};
        ADDR_IRQ_STATUS:  reg_rdata <= {13'h0000, irq_status};
        ADDR_IRQ_MASK:    reg_rdata <= {13'h0000, irq_mask};
        ADDR_TRIP_STATE:  reg_rdata <= {13'h0000, run, flag[1], flag[0]};
        default:          reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // calibration path
  // ---------------------------------------------------------------
  logic signed [24:0] cal_diff;
  logic               diff_valid;
  logic signed [17:0] gain_mult;
  logic signed [42:0] cal_prod;
  logic signed [26:0] cal_scaled;
  logic               cal_sat;

  always_comb begin
    gain_mult  = GAIN_UNITY + {{2{gain_trim_word[15]}}, gain_trim_word};
    cal_prod   = cal_diff * gain_mult;
    cal_scaled = cal_prod[42:16];
    cal_sat    = (cal_scaled > 27'sd8388607) || (cal_scaled < -27'sd8388608);
  end

  // offset taken off before the gain, both in result LSB units
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_diff   <= 25'sh0000000;
      diff_valid <= 1'b0;
    end else begin
      diff_valid <= conv_valid;
      if (conv_valid)
        cal_diff <= {conv_data[23], conv_data}
                  - {offset_trim_word[23], offset_trim_word};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_valid <= 1'b0;
      cal_data  <= 24'sh000000;
    end else begin
      cal_valid <= diff_valid;
      if (diff_valid) begin
        if (cal_scaled > 27'sd8388607)
          cal_data <= 24'sh7FFFFF;
        else if (cal_scaled < -27'sd8388608)
          cal_data <= 24'sh800000;
        else
          cal_data <= cal_scaled[23:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // fast filter and comparators
  // ---------------------------------------------------------------
  // go and halt of the normal path do not reach here at all
  assign run          = trip_enable && converter_enable;
  assign ff.run       = run;
  assign ff.bit_valid = mod_valid;
  assign ff.bit_in    = mod_bit;
  assign target       = DEGLITCH_TABLE[trip_deglitch_count];

  fast_sinc3 #(
    .OSR   (FAST_OSR),
    .ACC_W (3 * $clog2(FAST_OSR) + 2)
  ) u_fast_sinc3 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ff      (ff)
  );

  always_comb begin
    beyond[0] = (ff.sample > upper_trip_threshold)
             && (upper_trip_threshold != THRESH_HIGH_OFF);
    beyond[1] = (ff.sample < lower_trip_threshold)
             && (lower_trip_threshold != THRESH_LOW_OFF);
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_trip
    logic [7:0] count_plus;
    assign count_plus    = trip_count[ch] + 8'h01;
    assign trip_rise[ch] = run && ff.sample_valid && beyond[ch]
                        && (count_plus >= target) && !flag[ch];

    always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
        trip_count[ch] <= 8'h00;
        flag[ch]       <= 1'b0;
      end else if (ff.sample_valid) begin
        if (beyond[ch]) begin
          trip_count[ch] <= (trip_count[ch] >= target) ? trip_count[ch] : count_plus;
          flag[ch]       <= (count_plus >= target);
        end else begin
          trip_count[ch] <= 8'h00;
          flag[ch]       <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // fault output and pin 3
  // ---------------------------------------------------------------
  assign fault_level = trip_polarity ? (flag[0] || flag[1])
                                     : !(flag[0] || flag[1]);
  assign pin_value   = pin3_source_select ? fault_level : gpio3_level;

  // open-drain format releases the pin instead of driving it high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upper_trip_flag   <= 1'b0;
      lower_trip_flag   <= 1'b0;
      trip_fault_output <= 1'b1;
      pin3_out          <= 1'b0;
      pin3_oe           <= 1'b0;
    end else begin
      upper_trip_flag   <= flag[0];
      lower_trip_flag   <= flag[1];
      trip_fault_output <= fault_level;
      pin3_out          <= pin_value;
      pin3_oe           <= pin3_output_format ? !pin_value : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign irq_event     = {diff_valid && cal_sat, trip_rise[1], trip_rise[0]};
  assign wr_hit_status = reg_wr && (reg_addr == ADDR_IRQ_STATUS);

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(wr_hit_status ? reg_wdata[2:0] : 3'h0)) | irq_event;
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  offset_high_store_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == ADDR_OFFSET_HIGH |=> offset_trim_word[23:8] == $past(reg_wdata))
    else $error("offset high trim not stored");

  offset_low_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_OFFSET_LOW
      |=> reg_rdata == {$past(offset_trim_word[7:0]), 8'h00})
    else $error("offset low readback wrong");

  cfg_low_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_TRIP_CFG |=> reg_rdata[7:0] == 8'h00)
    else $error("trip config low byte not zero");

  trip_off_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    !run |=> ##1 !upper_trip_flag && !lower_trip_flag)
    else $error("trip flag alive with fast path off");

  count_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    run && ff.sample_valid && !beyond[0] |=> trip_count[0] == 8'h00 && !flag[0])
    else $error("deglitch count not restarted");

  trip_reach_a: assert property (@(posedge clk) disable iff (sys_rst)
    trip_rise[0] |=> flag[0] ##1 upper_trip_flag)
    else $error("upper flag missing after count reached");

  trip_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(flag[1]) |-> $past(ff.sample_valid) && $past(beyond[1]))
    else $error("lower flag set without an outside sample");

  high_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    upper_trip_threshold == THRESH_HIGH_OFF && ff.sample_valid |=> !$rose(flag[0]))
    else $error("upper detection active at full scale");

  fault_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 trip_fault_output == ($past(trip_polarity)
      ? ($past(flag[0]) || $past(flag[1])) : !($past(flag[0]) || $past(flag[1]))))
    else $error("fault level does not follow polarity and flags");

  pin_source_a: assert property (@(posedge clk) disable iff (sys_rst)
    pin3_source_select && !pin3_output_format |=> pin3_out == $past(fault_level) && pin3_oe)
    else $error("pin 3 does not carry the fault level");

  upper_trip_cov: cover property (@(posedge clk) disable iff (sys_rst) trip_rise[0]);
  lower_trip_cov: cover property (@(posedge clk) disable iff (sys_rst) trip_rise[1]);
  irq_cov:        cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
  cal_sat_cov:    cover property (@(posedge clk) disable iff (sys_rst) irq_event[2]);

endmodule

/* trip_cal_pkg.sv */
// constants for the shunt converter calibration and overcurrent trip block
// assumes one 200 MHz clock and a 16-bit register port with 8-bit addresses
package trip_cal_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h84;
  localparam logic [7:0] ADDR_OFFSET_LOW  = 8'h85;
  localparam logic [7:0] ADDR_GAIN        = 8'h86;
  localparam logic [7:0] ADDR_TRIP_CFG    = 8'h87;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hF0;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'hF1;
  localparam logic [7:0] ADDR_TRIP_STATE  = 8'hF2;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [23:0] OFFSET_RESET    = 24'h000000;
  localparam logic [15:0] GAIN_RESET      = 16'h0000;
  localparam logic [15:0] CFG_RESET       = 16'h0000;
  localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;
  localparam int          CFG_EN_BIT      = 15;
  localparam int          CFG_POL_BIT     = 14;
  localparam int          CFG_SPARE_BIT   = 13;
  localparam int          CFG_NUM_MSB     = 12;
  localparam int          CFG_NUM_LSB     = 8;
  localparam int          IRQ_UPPER_BIT   = 0;
  localparam int          IRQ_LOWER_BIT   = 1;
  localparam int          IRQ_SAT_BIT     = 2;

  // ---------------------------------------------------------------
  // fast path and calibration constants
  // ---------------------------------------------------------------
  localparam int                 FAST_OSR        = 64;
  localparam int                 FAST_SETTLE     = 3;
  localparam logic signed [15:0] THRESH_HIGH_OFF = 16'sh7FFF;
  localparam logic signed [15:0] THRESH_LOW_OFF  = 16'sh8000;
  localparam logic signed [17:0] GAIN_UNITY     = 18'sh10000;

  // consecutive fast samples needed per deglitch code
  localparam logic [7:0] DEGLITCH_TABLE [32] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h12,
    8'h14, 8'h16, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h30, 8'h38,
    8'h40, 8'h48, 8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h80
  };

endpackage

/* fast_filter_if.sv */
// carrier between the trip logic and its fast decimation filter
// assumes both ends share the single system clock
`timescale 1ns/100ps
interface fast_filter_if;
  logic               run;
  logic               bit_valid;
  logic               bit_in;
  logic               sample_valid;
  logic signed [15:0] sample;

  modport filt (input run, input bit_valid, input bit_in,
                output sample_valid, output sample);
  modport ctrl (output run, output bit_valid, output bit_in,
                input sample_valid, input sample);
endinterface

/* fast_sinc3.sv */
// third-order sinc decimator for the overcurrent fast path
// assumes a one-bit modulator stream qualified by a valid pulse
`timescale 1ns/100ps
module fast_sinc3
  import trip_cal_pkg::*;
#(
  parameter int OSR   = FAST_OSR,
  parameter int ACC_W = 3 * $clog2(FAST_OSR) + 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // filter link
  fast_filter_if.filt ff
);

  localparam int PH_W  = $clog2(OSR);
  localparam int SHIFT = 3 * $clog2(OSR) - 15;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(OSR - 1);

  logic signed [ACC_W-1:0] integ1, integ2, integ3;
  logic signed [ACC_W-1:0] dly1, dly2, dly3;
  logic signed [ACC_W-1:0] comb1, comb2, comb3, scaled;
  logic signed [ACC_W-1:0] step;
  logic [PH_W-1:0]         phase;
  logic [1:0]              settle;

  // ---------------------------------------------------------------
  // integrators
  // ---------------------------------------------------------------
  always_comb begin
    step  = ff.bit_in ? ACC_W'(1) : -ACC_W'(1);
    comb1 = integ3 - dly1;
    comb2 = comb1 - dly2;
    comb3 = comb2 - dly3;
    scaled = comb3 >>> SHIFT;
  end

  // wraparound arithmetic is intended, the combs undo it
  always_ff @(posedge clk) begin
    if (sys_rst || !ff.run) begin
      integ1 <= '0;
      integ2 <= '0;
      integ3 <= '0;
      phase  <= '0;
    end else if (ff.bit_valid) begin
      integ1 <= integ1 + step;
      integ2 <= integ2 + integ1;
      integ3 <= integ3 + integ2;
      phase  <= (phase == PH_LAST) ? '0 : phase + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // decimation and combs
  // ---------------------------------------------------------------
  // the first combs see a partly filled delay line, so they are held back
  always_ff @(posedge clk) begin
    if (sys_rst || !ff.run) begin
      dly1            <= '0;
      dly2            <= '0;
      dly3            <= '0;
      settle          <= '0;
      ff.sample_valid <= 1'b0;
      ff.sample       <= 16'sh0000;
    end else if (ff.bit_valid && phase == PH_LAST) begin
      dly1            <= integ3;
      dly2            <= comb1;
      dly3            <= comb2;
      settle          <= (settle == 2'(FAST_SETTLE)) ? settle : settle + 1'b1;
      ff.sample_valid <= (settle == 2'(FAST_SETTLE));
      if (scaled > ACC_W'(32767))
        ff.sample <= 16'sh7FFF;
      else if (scaled < -ACC_W'(32768))
        ff.sample <= 16'sh8000;
      else
        ff.sample <= scaled[15:0];
    end else begin
      ff.sample_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  decim_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
    ff.sample_valid |-> $past(ff.bit_valid) && $past(phase) == PH_LAST)
    else $error("fast sample not on the last of its modulator bits");

  halt_silent_a: assert property (@(posedge clk) disable iff (sys_rst)
    !ff.run |=> !ff.sample_valid)
    else $error("fast sample produced while the fast path is off");

  sample_cov: cover property (@(posedge clk) disable iff (sys_rst) ff.sample_valid);

endmodule

/* mod_source.sv */
// modulator stand-in feeding one-bit samples to the trip block
// assumes the bench clock; it makes samples only while go is high
`timescale 1ns/100ps
module mod_source (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // control from the bench
  input  wire logic        go,
  input  wire logic        ones,
  // modulator stream
  output logic             mod_valid,
  output logic             mod_bit,
  output logic [15:0]      pulses
);
  logic [1:0] phase;

  // ---------------------------------------------------------------
  // sample stream, one sample every fourth clock
  // ---------------------------------------------------------------
  // between samples the bit is inverted, so data taken off-strobe is wrong
  always_ff @(posedge clk) begin
    if (sys_rst || !go) begin
      phase     <= 2'h0;
      mod_valid <= 1'b0;
      mod_bit   <= !ones;
      pulses    <= 16'h0000;
    end else begin
      phase     <= phase + 2'h1;
      mod_valid <= (phase == 2'h3);
      mod_bit   <= (phase == 2'h3) ? ones : !ones;
      pulses    <= pulses + {15'h0000, mod_valid};
    end
  end
endmodule

/* test_shunt_trip_cal.sv */
// bench for the shunt calibration and overcurrent trip block
// assumes mod_source as modulator and the register map of the package
`timescale 1ns/100ps
module test_shunt_trip_cal
  import trip_cal_pkg::*;
;
  logic               clk, sys_rst, reg_wr, reg_rd, conv_valid, conv_en;
  logic               src_sel, fmt, gpio_lvl, go, ones, mod_valid, mod_bit;
  logic               cal_valid, pin3_out, pin3_oe, up_flag, lo_flag, fault, irq;
  logic [7:0]         reg_addr;
  logic [15:0]        reg_wdata, reg_rdata, pulses;
  logic signed [23:0] conv_data, cal_data;
  logic signed [15:0] thr_hi, thr_lo;
  int                 errors, num_checks, cycles;

  shunt_trip_cal shunt_trip_cal_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mod_valid(mod_valid), .mod_bit(mod_bit), .converter_enable(conv_en),
    .conv_valid(conv_valid), .conv_data(conv_data), .cal_valid(cal_valid),
    .cal_data(cal_data), .upper_trip_threshold(thr_hi), .lower_trip_threshold(thr_lo),
    .pin3_source_select(src_sel), .pin3_output_format(fmt), .gpio3_level(gpio_lvl),
    .pin3_out(pin3_out), .pin3_oe(pin3_oe), .upper_trip_flag(up_flag),
    .lower_trip_flag(lo_flag), .trip_fault_output(fault), .irq(irq));
  mod_source mod_source_i (.clk(clk), .sys_rst(sys_rst), .go(go), .ones(ones),
    .mod_valid(mod_valid), .mod_bit(mod_bit), .pulses(pulses));

  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(24'(reg_rdata), 24'(e));
  endtask
  task automatic cal(input logic [15:0] oh, ol, g, input logic [23:0] d, e);
    wr(ADDR_OFFSET_HIGH, oh);
    wr(ADDR_OFFSET_LOW, ol);
    wr(ADDR_GAIN, g);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_data  <= d;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
    #1;
    chk({23'h0, cal_valid}, 24'h1);
    chk(cal_data, e);
  endtask
  task automatic wait_lvl(input logic low, input logic val);
    for (int i = 0; i < 40000; i++) begin
      @(posedge clk);
      #1;
      if ((low ? lo_flag : up_flag) === val) break;
    end
  endtask
  // restart the fast path, then count samples until the flag rises
  task automatic trip(input logic [4:0] code, input logic up, input int n);
    go   <= 1'b0;
    ones <= up;
    wr(ADDR_TRIP_CFG, 16'h0000);
    wr(ADDR_TRIP_CFG, {3'b100, code, 8'h00});
    @(posedge clk);
    go <= 1'b1;
    wait_lvl(!up, 1'b1);
    chk(24'(pulses), 24'((3 + n) * 64));
  endtask

  // ---------------------------------------------------------------
  // clock, timeout and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, conv_valid, src_sel, fmt, gpio_lvl, go, ones} = 9'h100;
    {reg_addr, reg_wdata, conv_data, thr_hi, thr_lo} = '0;
    conv_en = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_OFFSET_HIGH, 16'h0000);
    rd(ADDR_OFFSET_LOW, 16'h0000);
    rd(ADDR_GAIN, 16'h0000);
    rd(ADDR_TRIP_CFG, 16'h0000);
    wr(ADDR_OFFSET_HIGH, 16'hFFFF);
    rd(ADDR_OFFSET_HIGH, 16'hFFFF);
    wr(ADDR_OFFSET_LOW, 16'hFFFF);
    rd(ADDR_OFFSET_LOW, 16'hFF00);
    wr(ADDR_TRIP_CFG, 16'h5FFF);
    rd(ADDR_TRIP_CFG, 16'h5F00);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'h0000);
    cal(16'h0001, 16'h0000, 16'h8000, 24'h001100, 24'h000800);
    cal(16'h0001, 16'h0000, 16'h7FFF, 24'h001100, 24'h0017FF);
    cal(16'hFFFF, 16'hFF00, 16'h0000, 24'h000000, 24'h000001);
    cal(16'h0000, 16'h0000, 16'h7FFF, 24'h7FFFFF, 24'h7FFFFF);
    rd(ADDR_IRQ_STATUS, 16'h0004);
    wr(ADDR_IRQ_STATUS, 16'h0004);
    rd(ADDR_IRQ_STATUS, 16'h0000);
    thr_lo  <= THRESH_LOW_OFF;
    src_sel <= 1'b1;
    wr(ADDR_IRQ_MASK, 16'h0001);
    trip(5'd0, 1'b1, 1);
    chk({21'h0, fault, pin3_out, pin3_oe}, 24'h1);
    rd(ADDR_TRIP_STATE, 16'h0005);
    chk({23'h0, irq}, 24'h1);
    wr(ADDR_TRIP_CFG, 16'hC000);
    src_sel  <= 1'b0;
    gpio_lvl <= 1'b1;
    fmt      <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({21'h0, fault, pin3_out, pin3_oe}, 24'h6);
    ones <= 1'b0;
    wait_lvl(1'b0, 1'b0);
    chk({23'h0, up_flag}, 24'h0);
    wr(ADDR_TRIP_CFG, 16'h0000);
    wr(ADDR_IRQ_STATUS, 16'h0001);
    rd(ADDR_IRQ_STATUS, 16'h0000);
    chk({23'h0, irq}, 24'h0);
    thr_hi <= THRESH_HIGH_OFF;
    thr_lo <= 16'sh0000;
    trip(5'd0, 1'b0, 1);
    chk({23'h0, up_flag}, 24'h0);
    wr(ADDR_TRIP_CFG, 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    chk({23'h0, lo_flag}, 24'h0);
    thr_hi <= 16'sh0000;
    thr_lo <= THRESH_LOW_OFF;
    trip(5'd5, 1'b1, 6);
    trip(5'd12, 1'b1, 14);
    trip(5'd31, 1'b1, 128);
    thr_hi <= THRESH_HIGH_OFF;
    for (int u = 0; u < 2; u++) begin
      go   <= 1'b0;
      ones <= u[0];
      wr(ADDR_TRIP_CFG, 16'h8000);
      @(posedge clk);
      go <= 1'b1;
      repeat (1600) @(posedge clk);
      #1;
      chk({22'h0, up_flag, lo_flag}, 24'h0);
    end
    // converter off: the fast path must stay idle although samples are outside
    conv_en <= 1'b0;
    thr_hi  <= 16'sh0000;
    repeat (1600) @(posedge clk);
    #1;
    chk({23'h0, up_flag}, 24'h0);
    stop_test();
  end
endmodule
